// *** src/dgs_display_gen_seq.v ***
// Display generator sequencer: microprogrammed refresh memory control with APB register access
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps
`include "dgs_defs.vh"
// Notes on behaviour
// - Mode 1 reads a 12-bit element into readback, then updates operating points; mode 2 skips update.
// - Mode 3 writes a 12-bit value shaped by setup registers, then updates operating points.
// - Mode 4 updates operating points first, then requests the write cycle.
// - Mode 5 only updates operating points, with no memory cycle.
// - Modes 1-5 start only on host access with address bits 15 and 7 both one.
// - Mode 6 tests additive-write and raster bit, then rotates raster data left once.
// - Mode 6 either writes foreground or background data then updates, or only updates.
// - DMA loops run once per word and stop at word count zero.
// - Mode 7 loads foreground from host data, writes it, then updates operating points.
// - Mode 8 reads an element into readback per word, then updates operating points.
// - Microprogram store is 256 locations of 20 bits.
// - Next-address register is 6 bits, so a program spans 64 words.
// - Two resolution keys give the upper two store address bits, selecting one of four programs.
// - Two condition selectors form the low two next-address bits, forced or conditional.
// - One microinstruction may repeat every cycle until a selected condition changes.
// - Generator DMA active when dma_go and either destination or source flag.
// - Quasi-DMA active only when dma_go, destination and source flags all set.
// - Operation pending during generator DMA, or on unheld host access with bits 15, 7.
// - Hold bit suppresses updates on programmed-I/O reads, not during DMA readback.
// - During quasi-DMA, update_only blocks the write request but allows the update.
// - Sequencer waits for cycle_complete from the timing generator before proceeding.
// - 12-bit word counter, high byte write starts DMA, half-clock decrement, zero flag.
// - Select code 000 forces zero, 111 forces one; both forced is an unconditional jump.
module dgs_display_gen_seq #(
  parameter DATA_W  = 12,
  parameter UW_W    = 20,
  parameter UC_DEPTH = 256,
  parameter NA_W    = 6
) (
  input  wire              pclk,
  input  wire              presetn,
  input  wire              psel,
  input  wire              penable,
  input  wire              pwrite,
  input  wire [11:0]       paddr,
  input  wire [31:0]       pwdata,
  input  wire [3:0]        pstrb,
  output reg  [31:0]       prdata,
  output wire              pready,
  output wire              pslverr,
  input  wire              resolution_key_a,
  input  wire              resolution_key_b,
  input  wire              host_bus_write,
  input  wire              host_bus_read,
  input  wire              bus_addr_bit_high,
  input  wire              bus_addr_bit_mid,
  input  wire              dma_hold_request,
  input  wire              move_reg_selected,
  input  wire              move_or_ack,
  input  wire              valid_pio,
  input  wire [DATA_W-1:0] host_data,
  input  wire              cycle_complete,
  input  wire [DATA_W-1:0] mem_read_data,
  output wire [1:0]        mem_opcode,
  output reg  [DATA_W-1:0] mem_write_data,
  output wire              gen_write,
  output wire              gen_ack,
  output wire              gen_ready,
  output reg               dma_go,
  output wire              word_count_zero,
  output reg  [NA_W-1:0]   next_address
);

  reg  [UW_W-1:0]   ucode [0:UC_DEPTH-1];
  reg  [5:0]        ctrl;
  reg  [DATA_W-1:0] word_count;
  reg  [DATA_W-1:0] foreground;
  reg  [DATA_W-1:0] background;
  reg  [7:0]        raster;
  reg  [DATA_W-1:0] readback;
  reg  [DATA_W-1:0] point_x;
  reg  [DATA_W-1:0] point_y;
  reg  [7:0]        uc_index;
  reg               half_en;
  reg  [NA_W-1:0]   next_next_address;
  reg  [31:0]       next_prdata;
  reg               mapped;

  wire              run;
  wire              hold_update_bit;
  wire              gen_destination_flag;
  wire              gen_source_flag;
  wire              gen_dma_active;
  wire              quasi_dma_active;
  wire              operation_pending;
  wire              update_only;
  wire              io_start;
  wire              raster_bit;
  wire [7:0]        uc_addr;
  wire [UW_W-1:0]   uword;
  wire [2:0]        c1_sel;
  wire [2:0]        c2_sel;
  wire              cond1;
  wire              cond2;
  wire              act;
  wire              apb_setup;
  wire              apb_write;
  wire              wc_high_write;
  wire              word_count_decrement;

  // Condition selector: 000 and 111 are forced levels, the rest pick a term
  function cond_pick;
    input [2:0] sel;
    input [5:0] terms;
    begin
      case (sel)
        `DGS_SEL_ZERO: cond_pick = 1'b0;
        `DGS_SEL_ONE:  cond_pick = 1'b1;
        default:       cond_pick = terms[sel - 3'h1];
      endcase
    end
  endfunction

  // Byte-lane merge for 12-bit registers
  function [DATA_W-1:0] merge12;
    input [DATA_W-1:0] old;
    input [31:0]       wd;
    input [3:0]        strb;
    begin
      merge12 = old;
      if (strb[0]) begin
        merge12[7:0] = wd[7:0];
      end
      if (strb[1]) begin
        merge12[DATA_W-1:8] = wd[DATA_W-1:8];
      end
    end
  endfunction

  assign run                  = ctrl[`DGS_CTRL_RUN];
  assign hold_update_bit      = ctrl[`DGS_CTRL_HOLD];
  assign gen_destination_flag = ctrl[`DGS_CTRL_DEST];
  assign gen_source_flag      = ctrl[`DGS_CTRL_SRC];
  assign raster_bit           = raster[7];

  assign gen_dma_active   = dma_go & (gen_destination_flag | gen_source_flag);
  assign quasi_dma_active = dma_go & gen_destination_flag & gen_source_flag;
  assign io_start         = host_bus_write | host_bus_read;
  assign operation_pending = gen_dma_active |
                             (~dma_hold_request & bus_addr_bit_high & bus_addr_bit_mid & io_start);
  // During quasi-DMA, skip the write when the raster bit is clear and additive write or no background fill applies
  assign update_only = quasi_dma_active & ~raster_bit &
                       (ctrl[`DGS_CTRL_ADDITIVE] | ~ctrl[`DGS_CTRL_BGBIT]);

  assign uc_addr = {resolution_key_a, resolution_key_b, next_address};
  assign uword   = ucode[uc_addr];
  assign c1_sel  = uword[`DGS_UW_C1_HI:`DGS_UW_C1_LO];
  assign c2_sel  = uword[`DGS_UW_C2_HI:`DGS_UW_C2_LO];
  assign act     = run & half_en;

  assign cond1 = cond_pick(c1_sel, {cycle_complete, update_only, move_reg_selected,
                                    valid_pio, gen_source_flag, operation_pending});
  assign cond2 = cond_pick(c2_sel, {host_bus_write, io_start, gen_dma_active,
                                    move_or_ack, hold_update_bit, quasi_dma_active});

  // A stopped sequencer requests no memory cycle and raises no strobe
  assign mem_opcode = run ? uword[`DGS_UW_OPCODE_HI:`DGS_UW_OPCODE_LO] : `DGS_OP_NOP;
  assign gen_write  = run & uword[`DGS_UW_DGWRT];
  assign gen_ack    = run & uword[`DGS_UW_DGACK];
  assign gen_ready  = run & uword[`DGS_UW_EREADY];

  assign word_count_zero      = (word_count == {DATA_W{1'b0}});
  // A bump at zero is dropped so the count never wraps
  assign word_count_decrement = act & uword[`DGS_UW_BUMPWC] & ~word_count_zero;

  assign apb_setup     = psel & ~penable;
  assign apb_write     = psel & penable & pwrite;
  assign wc_high_write = apb_write & (paddr == `DGS_OFF_WORDCNT) & pstrb[1];
  // Zero wait states; unmapped offsets answer with an error
  assign pready        = 1'b1;
  assign pslverr       = psel & penable & ~mapped;

  // Half clock enable: one instruction every second pclk
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      half_en <= 1'b0;
    end else begin
      half_en <= ~half_en;
    end
  end

  // Next address: upper bits from the microword, low two from the selectors
  always @* begin
    next_next_address = {uword[`DGS_UW_NEXT_HI:`DGS_UW_NEXT_LO], cond2, cond1};
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      next_address <= {NA_W{1'b0}};
    end else if (!run) begin
      next_address <= {NA_W{1'b0}};
    end else if (half_en) begin
      next_address <= next_next_address;
    end
  end

  // Microprogram store, loaded by software through an index/data pair
  always @(posedge pclk) begin
    if (apb_write && paddr == `DGS_OFF_UC_DATA) begin
      ucode[uc_index] <= pwdata[UW_W-1:0];
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      uc_index <= 8'h00;
    end else if (apb_write && paddr == `DGS_OFF_UC_INDEX) begin
      uc_index <= pwdata[7:0];
    end else if (apb_write && paddr == `DGS_OFF_UC_DATA) begin
      uc_index <= uc_index + 8'h01;
    end
  end

  // Control register
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `DGS_CTRL_RESET;
    end else if (apb_write && paddr == `DGS_OFF_CTRL && pstrb[0]) begin
      ctrl <= pwdata[5:0];
    end
  end

  // Word counter and DMA go; loading the high byte starts a transfer
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_count <= {DATA_W{1'b0}};
      dma_go     <= 1'b0;
    end else begin
      if (apb_write && paddr == `DGS_OFF_WORDCNT) begin
        word_count <= merge12(word_count, pwdata, pstrb);
      end else if (word_count_decrement) begin
        word_count <= word_count - {{(DATA_W-1){1'b0}}, 1'b1};
      end
      if (wc_high_write) begin
        dma_go <= 1'b1;
      end else if (word_count_zero) begin
        dma_go <= 1'b0;
      end
    end
  end

  // Foreground, background and raster data registers
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      foreground <= {DATA_W{1'b0}};
      background <= {DATA_W{1'b0}};
      raster     <= 8'h00;
    end else begin
      if (act && uword[`DGS_UW_LDFG]) begin
        foreground <= host_data;
      end else if (apb_write && paddr == `DGS_OFF_FOREGROUND) begin
        foreground <= merge12(foreground, pwdata, pstrb);
      end
      if (apb_write && paddr == `DGS_OFF_BACKGROUND) begin
        background <= merge12(background, pwdata, pstrb);
      end
      if (act && uword[`DGS_UW_SHIFT]) begin
        raster <= {raster[6:0], raster[7]};
      end else if (apb_write && paddr == `DGS_OFF_RASTER && pstrb[0]) begin
        raster <= pwdata[7:0];
      end
    end
  end

  // Write data: foreground for set raster bits or outside quasi-DMA, else background
  // A foreground load forwards host data at once, so a following write never carries stale data
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_write_data <= {DATA_W{1'b0}};
    end else if (quasi_dma_active && !raster_bit) begin
      mem_write_data <= background;
    end else if (act && uword[`DGS_UW_LDFG]) begin
      mem_write_data <= host_data;
    end else begin
      mem_write_data <= foreground;
    end
  end

  // Readback captured when a read cycle completes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      readback <= {DATA_W{1'b0}};
    end else if (run && mem_opcode == `DGS_OP_READ && cycle_complete) begin
      readback <= mem_read_data;
    end
  end

  // Operating point registers, stepped by the update pulses
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      point_x <= {DATA_W{1'b0}};
      point_y <= {DATA_W{1'b0}};
    end else begin
      if (act && uword[`DGS_UW_UPDTX]) begin
        point_x <= point_x + {{(DATA_W-1){1'b0}}, 1'b1};
      end else if (apb_write && paddr == `DGS_OFF_POINT_X) begin
        point_x <= merge12(point_x, pwdata, pstrb);
      end
      if (act && uword[`DGS_UW_UPDTY]) begin
        point_y <= point_y + {{(DATA_W-1){1'b0}}, 1'b1};
      end else if (apb_write && paddr == `DGS_OFF_POINT_Y) begin
        point_y <= merge12(point_y, pwdata, pstrb);
      end
    end
  end

  // APB read decode
  always @* begin
    next_prdata = 32'h00000000;
    mapped      = 1'b1;
    case (paddr)
      `DGS_OFF_CTRL:       next_prdata[5:0] = ctrl;
      `DGS_OFF_STATUS:     next_prdata[10:0] = {quasi_dma_active, gen_dma_active, dma_go,
                                                word_count_zero, operation_pending, next_address};
      `DGS_OFF_WORDCNT:    next_prdata[DATA_W-1:0] = word_count;
      `DGS_OFF_FOREGROUND: next_prdata[DATA_W-1:0] = foreground;
      `DGS_OFF_BACKGROUND: next_prdata[DATA_W-1:0] = background;
      `DGS_OFF_RASTER:     next_prdata[7:0] = raster;
      `DGS_OFF_READBACK:   next_prdata[DATA_W-1:0] = readback;
      `DGS_OFF_POINT_X:    next_prdata[DATA_W-1:0] = point_x;
      `DGS_OFF_POINT_Y:    next_prdata[DATA_W-1:0] = point_y;
      `DGS_OFF_UC_INDEX:   next_prdata[7:0] = uc_index;
      `DGS_OFF_UC_DATA:    next_prdata[UW_W-1:0] = ucode[uc_index];
      default:             mapped = 1'b0;
    endcase
  end

  // Read data is captured in the setup phase and stands through the access phase
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (apb_setup) begin
      prdata <= next_prdata;
    end
  end

endmodule // dgs_display_gen_seq

// *** inc/dgs_defs.vh ***
// Register map, field positions, reset values and codes for the display generator sequencer
`ifndef DGS_DEFS_VH
`define DGS_DEFS_VH

// Register byte offsets
`define DGS_OFF_CTRL       12'h000
`define DGS_OFF_STATUS     12'h004
`define DGS_OFF_WORDCNT    12'h008
`define DGS_OFF_FOREGROUND 12'h00C
`define DGS_OFF_BACKGROUND 12'h010
`define DGS_OFF_RASTER     12'h014
`define DGS_OFF_READBACK   12'h018
`define DGS_OFF_POINT_X    12'h01C
`define DGS_OFF_POINT_Y    12'h020
`define DGS_OFF_UC_INDEX   12'h024
`define DGS_OFF_UC_DATA    12'h028

// Control register fields
`define DGS_CTRL_RUN       0
`define DGS_CTRL_HOLD      1
`define DGS_CTRL_ADDITIVE  2
`define DGS_CTRL_BGBIT     3
`define DGS_CTRL_DEST      4
`define DGS_CTRL_SRC       5
`define DGS_CTRL_RESET     6'h00

// Microinstruction fields
`define DGS_UW_OPCODE_LO   0
`define DGS_UW_OPCODE_HI   1
`define DGS_UW_EREADY      2
`define DGS_UW_DGACK       3
`define DGS_UW_DGWRT       4
`define DGS_UW_LDFG        5
`define DGS_UW_UPDTY       6
`define DGS_UW_UPDTX       7
`define DGS_UW_SHIFT       8
`define DGS_UW_BUMPWC      9
`define DGS_UW_C1_LO       10
`define DGS_UW_C1_HI       12
`define DGS_UW_C2_LO       13
`define DGS_UW_C2_HI       15
`define DGS_UW_NEXT_LO     16
`define DGS_UW_NEXT_HI     19

// Condition select codes
`define DGS_SEL_ZERO       3'h0
`define DGS_SEL_ONE        3'h7

// Timing generator opcodes
`define DGS_OP_NOP         2'h0
`define DGS_OP_READ        2'h1
`define DGS_OP_WRITE       2'h2

`endif

// *** verif/dgs_seq_asserts.sv ***
// Port-level assertions for the display generator sequencer
`timescale 1ns/1ps
`include "dgs_defs.vh"
module dgs_seq_asserts #(
  parameter NA_W = 6
) (
  input wire logic            pclk,
  input wire logic            presetn,
  input wire logic            psel,
  input wire logic            penable,
  input wire logic            pwrite,
  input wire logic [11:0]     paddr,
  input wire logic [31:0]     pwdata,
  input wire logic [3:0]      pstrb,
  input wire logic [31:0]     prdata,
  input wire logic            pready,
  input wire logic            pslverr,
  input wire logic [1:0]      mem_opcode,
  input wire logic            cycle_complete,
  input wire logic            dma_go,
  input wire logic            word_count_zero,
  input wire logic [NA_W-1:0] next_address
);
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  wire acc = psel && penable;
  wire wc_hi_wr = acc && pwrite && paddr == `DGS_OFF_WORDCNT && pstrb[1];
  wire ctrl_wr = acc && pwrite && paddr == `DGS_OFF_CTRL;
  AST_RESET_IDLE: assert property ($rose(presetn) |-> next_address == '0 && mem_opcode == `DGS_OP_NOP)
    else $error("Sequencer not idle after reset");
  AST_ADDR_HALF_RATE: assert property (!$stable(next_address) |=> $stable(next_address))
    else $error("Address changed on consecutive clocks");
  AST_DMA_START: assert property ($rose(dma_go) |-> $past(wc_hi_wr))
    else $error("Transfer started without a count high byte write");
  AST_DMA_STOP: assert property ($fell(dma_go) |-> word_count_zero)
    else $error("Transfer ended with words left");
  AST_WC_LOAD: assert property (wc_hi_wr && pstrb[0] |=> word_count_zero == ($past(pwdata[11:0]) == 12'h000))
    else $error("Zero flag wrong after count load");
  AST_PREADY: assert property (pready)
    else $error("Wait state inserted");
  AST_ERR_ACCESS: assert property (pslverr |-> acc && prdata == 32'h0)
    else $error("Error response outside access or with data");
  AST_OP_STANDS: assert property ($changed(mem_opcode) |-> $changed(next_address) || $past(ctrl_wr))
    else $error("Cycle request changed within an instruction");
  cover property ($rose(dma_go));
  cover property (pslverr);
  cover property (mem_opcode == `DGS_OP_READ && cycle_complete);
  cover property (mem_opcode == `DGS_OP_WRITE && cycle_complete);
endmodule // dgs_seq_asserts

bind dgs_display_gen_seq dgs_seq_asserts #(.NA_W(NA_W)) dgs_seq_asserts_inst (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .mem_opcode(mem_opcode), .cycle_complete(cycle_complete),
  .dma_go(dma_go), .word_count_zero(word_count_zero), .next_address(next_address));

// *** verif/dgs_mem_timing_model.sv ***
// Behavioural refresh memory timing generator answering sequencer cycle requests
`timescale 1ns/1ps
`include "dgs_defs.vh"
module dgs_mem_timing_model (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic [1:0]  mem_opcode,
  input  wire logic [11:0] mem_write_data,
  output logic             cycle_complete,
  output logic [11:0]      mem_read_data,
  output logic [1:0]       last_op,
  output logic [11:0]      last_data,
  output int               done_count
);
  logic [2:0]  delay;
  logic [11:0] rd_val;
  // Read bus carries junk except while a read or write cycle completes
  assign mem_read_data = cycle_complete ? rd_val : ~rd_val;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cycle_complete <= 1'b0;
      delay <= 3'h0;
      done_count <= 0;
      last_op <= 2'h0;
      last_data <= 12'h000;
      rd_val <= 12'h000;
    end else if (mem_opcode == `DGS_OP_NOP) begin
      cycle_complete <= 1'b0;
      delay <= 3'($urandom % 5);
      rd_val <= 12'($urandom);
    end else if (!cycle_complete && delay != 3'h0) begin
      delay <= delay - 3'h1;
    end else if (!cycle_complete) begin
      cycle_complete <= 1'b1;
      done_count <= done_count + 1;
      last_op <= mem_opcode;
      last_data <= mem_opcode == `DGS_OP_WRITE ? mem_write_data : rd_val;
    end
  end
endmodule // dgs_mem_timing_model

// *** verif/dgs_display_gen_seq_tb_top.sv ***
// Self-checking bench for the display generator sequencer
`timescale 1ns/1ps
`include "dgs_defs.vh"
module dgs_display_gen_seq_tb_top;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err;
  logic [11:0] paddr = 12'h000, host_data = 12'h000, mem_read_data, mem_write_data, last_data, x0;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0]  pstrb = 4'hF;
  logic        key_b = 1'b0, hb_wr = 1'b0, hb_rd = 1'b0, a15 = 1'b0, a7 = 1'b0, hold_rq = 1'b0;
  logic        pready, pslverr, cycle_complete, dma_go, word_count_zero, gen_w, gen_a, gen_r;
  logic [11:0] bg;
  logic [7:0]  ras;
  logic [1:0]  mem_opcode, last_op;
  logic [5:0]  next_address;
  int          err_count = 0, comparisons = 0, cycles = 0, done_count, n, c0;
  dgs_display_gen_seq dgs_display_gen_seq_inst (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .resolution_key_a(1'b0), .resolution_key_b(key_b), .host_bus_write(hb_wr),
    .host_bus_read(hb_rd), .bus_addr_bit_high(a15), .bus_addr_bit_mid(a7), .dma_hold_request(hold_rq),
    .move_reg_selected(1'b0), .move_or_ack(1'b0), .valid_pio(1'b0), .host_data(host_data),
    .cycle_complete(cycle_complete), .mem_read_data(mem_read_data), .mem_opcode(mem_opcode),
    .mem_write_data(mem_write_data), .gen_write(gen_w), .gen_ack(gen_a), .gen_ready(gen_r), .dma_go(dma_go),
    .word_count_zero(word_count_zero), .next_address(next_address));
  dgs_mem_timing_model dgs_mem_timing_model_inst (.pclk(pclk), .presetn(presetn), .mem_opcode(mem_opcode),
    .mem_write_data(mem_write_data), .cycle_complete(cycle_complete), .mem_read_data(mem_read_data),
    .last_op(last_op), .last_data(last_data), .done_count(done_count));
  initial forever #2 pclk = ~pclk;
  task automatic summarize();
    if (err_count == 0 && comparisons > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      err_count++;
      $display("[FAIL] %0t run did not finish", $time);
      summarize();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  function automatic logic [31:0] uw(logic [1:0] op, logic ldfg, logic upd, logic [2:0] c1, logic [3:0] up);
    return {12'h0, up, `DGS_SEL_ZERO, c1, upd, 1'b0, upd, upd, ldfg, 3'b000, op};
  endfunction
  // Idle waits on pending work, then one cycle request looping on completion, then update and bump
  task automatic load(input logic [7:0] base, input logic [1:0] op, input logic ldfg);
    apb(1'b1, `DGS_OFF_UC_INDEX, {24'h0, base});
    apb(1'b1, `DGS_OFF_UC_DATA, uw(`DGS_OP_NOP, 1'b0, 1'b0, 3'h1, 4'h0));
    apb(1'b1, `DGS_OFF_UC_DATA, uw(`DGS_OP_NOP, ldfg, 1'b0, `DGS_SEL_ZERO, 4'h1));
    apb(1'b1, `DGS_OFF_UC_INDEX, {24'h0, base + 8'h04});
    apb(1'b1, `DGS_OFF_UC_DATA, uw(op, 1'b0, 1'b0, 3'h6, 4'h1));
    apb(1'b1, `DGS_OFF_UC_DATA, uw(`DGS_OP_NOP, 1'b0, 1'b1, `DGS_SEL_ZERO, 4'h0));
  endtask
  task automatic dma(input logic kb, input logic q);
    apb(1'b1, `DGS_OFF_CTRL, q ? 32'h30 : 32'h10);
    key_b <= kb;
    host_data <= 12'($urandom);
    ras = 8'($urandom);
    bg = 12'($urandom);
    apb(1'b1, `DGS_OFF_RASTER, {24'h0, ras});
    apb(1'b1, `DGS_OFF_BACKGROUND, {20'h0, bg});
    apb(1'b1, `DGS_OFF_CTRL, q ? 32'h31 : 32'h11);
    n = 1 + $urandom % 6;
    apb(1'b0, `DGS_OFF_POINT_X, 32'h0);
    x0 = rd[11:0];
    c0 = done_count;
    apb(1'b1, `DGS_OFF_WORDCNT, 32'(n));
    @(posedge pclk);
    while (dma_go !== 1'b0 || next_address !== 6'h00) @(posedge pclk);
    check(done_count - c0, n, "words moved");
    check(word_count_zero, 1'b1, "count flag");
    check(last_op, kb ? `DGS_OP_WRITE : `DGS_OP_READ, "cycle kind");
    if (kb) begin
      check(last_data, q && !ras[7] ? bg : host_data, "written data");
    end else begin
      apb(1'b0, `DGS_OFF_READBACK, 32'h0);
      check(rd, {20'h0, last_data}, "transfer readback");
    end
    check({gen_w, gen_a, gen_r}, 3'h0, "idle strobes");
    apb(1'b0, `DGS_OFF_POINT_X, 32'h0);
    check(rd, {20'h0, x0 + 12'(n)}, "point after transfer");
  endtask
  initial begin
    void'($urandom(32'hD2A3FCD2));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check(next_address, 6'h00, "idle address");
    check(word_count_zero, 1'b1, "zero count");
    apb(1'b0, 12'hFFC, 32'h0);
    check(err, 1'b1, "unmapped error");
    check(rd, 32'h0, "unmapped data");
    apb(1'b0, `DGS_OFF_CTRL, 32'h0);
    check(rd, 32'h0, "control reset value");
    apb(1'b0, `DGS_OFF_STATUS, 32'h0);
    check(rd, 32'h80, "idle status");
    load(8'h00, `DGS_OP_READ, 1'b0);
    load(8'h40, `DGS_OP_WRITE, 1'b1);
    apb(1'b1, `DGS_OFF_CTRL, 32'h11);
    c0 = done_count;
    hb_wr <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      {a15, a7, hold_rq} <= i == 0 ? 3'b100 : i == 1 ? 3'b010 : 3'b111;
      repeat (16) @(posedge pclk);
    end
    check(done_count - c0, 0, "stray start");
    hb_wr <= 1'b0;
    {a15, a7, hold_rq} <= 3'b110;
    repeat (3) begin
      apb(1'b0, `DGS_OFF_POINT_X, 32'h0);
      x0 = rd[11:0];
      c0 = done_count;
      hb_rd <= 1'b1;
      while (mem_opcode === `DGS_OP_NOP) @(posedge pclk);
      hb_rd <= 1'b0;
      while (done_count == c0 || next_address !== 6'h00) @(posedge pclk);
      check(done_count - c0, 1, "single read");
      apb(1'b0, `DGS_OFF_READBACK, 32'h0);
      check(rd, {20'h0, last_data}, "readback");
      apb(1'b0, `DGS_OFF_POINT_X, 32'h0);
      check(rd, {20'h0, x0 + 12'h001}, "point after read");
    end
    for (int i = 0; i < 8; i++) dma(i[0], i[2]);
    summarize();
  end
endmodule // dgs_display_gen_seq_tb_top
